// ### inc/tcdfp_pkg.sv
// Package for the Type-C DFP attach and power control block
package tcdfp_pkg;

    // Termination seen on one CC line
    typedef enum logic [1:0] {
        TERM_OPEN,
        TERM_RD,
        TERM_RA
    } tcdfp_term_t;

    // Advertised source current level on the attached CC line
    typedef enum logic [1:0] {
        ADV_STD,
        ADV_1A5,
        ADV_3A0
    } tcdfp_adv_t;

    // Top-level states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_EN,
        ST_UNATTACHED,
        ST_DEGLITCH,
        ST_ATTACHED,
        ST_AUDIO,
        ST_DEBUG
    } tcdfp_state_t;

    // Debounced CC observation, both lines together
    typedef struct packed {
        tcdfp_term_t cc1;
        tcdfp_term_t cc2;
    } tcdfp_cc_t;

    // Power and flag outputs travel together
    typedef struct packed {
        logic vbus_on;
        logic vconn_cc1;
        logic vconn_cc2;
        logic orient_oe;
        logic audio_oe;
        logic debug_oe;
    } tcdfp_out_t;

    // Deglitch interval in cycles of the 25 MHz sampling clock
    localparam int unsigned DEGLITCH_CYCLES = 16;
    localparam int unsigned CNT_W = 16;

    // Reset values
    localparam tcdfp_out_t OUT_RST = '{default: 1'b0};
    localparam tcdfp_cc_t CC_RST = '{cc1: TERM_OPEN, cc2: TERM_OPEN};
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

endpackage

// ### logic/tcdfp_deglitch.sv
// Deglitch filter for the CC termination state
`timescale 1ns/1ps
`default_nettype none

module tcdfp_deglitch
    import tcdfp_pkg::*;
#(
    parameter int unsigned CYCLES = DEGLITCH_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Control
    input wire logic run_i,
    // Raw observation
    input var tcdfp_cc_t raw_i,
    // Filtered observation
    output tcdfp_cc_t stable_o,
    output logic settled_o
);

    typedef struct packed {
        tcdfp_cc_t last;
        tcdfp_cc_t stable;
        logic [CNT_W-1:0] cnt;
        logic settled;
    } tcdfp_dg_state_t;

    localparam logic [CNT_W-1:0] TERMINAL = CNT_W'(CYCLES - 1);

    tcdfp_dg_state_t state_ff;
    tcdfp_dg_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.last = raw_i;
        if (!run_i) begin
            nxt_state.cnt = CNT_RST;
            nxt_state.settled = 1'b0;
            nxt_state.stable = CC_RST;
        end else if (raw_i != state_ff.last) begin
            // Any change restarts the interval
            nxt_state.cnt = CNT_RST;
            nxt_state.settled = 1'b0;
        end else if (state_ff.cnt == TERMINAL) begin
            nxt_state.stable = raw_i;
            nxt_state.settled = 1'b1;
        end else begin
            nxt_state.cnt = state_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_ff <= '{last: CC_RST, stable: CC_RST, cnt: CNT_RST, settled: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign stable_o = state_ff.stable;
    assign settled_o = state_ff.settled;

endmodule

`default_nettype wire

// ### logic/tcdfp_ctrl.sv
// Type-C DFP attach detection, power switching and current advertisement
`timescale 1ns/1ps
`default_nettype none

module tcdfp_ctrl
    import tcdfp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Supply and enable
    input wire logic aux_uvlo_ok_i,
    input wire logic enable_i,
    // Current advertisement selects
    input wire logic charge_select_i,
    input wire logic high_current_select_i,
    // Comparator results on each CC line
    input var tcdfp_term_t cc1_term_i,
    input var tcdfp_term_t cc2_term_i,
    // Analog protection inputs
    input wire logic vbus_fault_i,
    input wire logic vconn_ilim_i,
    // Power switch controls
    output logic bus_power_input_sw_o,
    output logic cable_power_input_cc1_o,
    output logic cable_power_input_cc2_o,
    // Advertisement
    output tcdfp_adv_t adv_level_o,
    output logic adv_cc1_o,
    output logic adv_cc2_o,
    output logic monitor_on_o,
    // Open-drain flags, driven low while the enable is high
    output logic orientation_flag_o,
    output logic orientation_flag_oe_o,
    output logic audio_flag_o,
    output logic audio_flag_oe_o,
    output logic debug_flag_o,
    output logic debug_flag_oe_o
);

    typedef struct packed {
        tcdfp_state_t st;
        tcdfp_out_t outs;
        tcdfp_adv_t adv;
        logic on_cc2;
        logic monitor;
        logic adv_cc1;
        logic adv_cc2;
    } tcdfp_ctrl_state_t;

    tcdfp_ctrl_state_t state_ff;
    tcdfp_ctrl_state_t nxt_state;

    tcdfp_cc_t raw_cc;
    tcdfp_cc_t stable_cc;
    logic settled;
    logic ufp_cc1;
    logic ufp_cc2;
    logic attach_seen;

    ////////////////////////////////////////////////////////////////////////////
    // CC observation and deglitch

    assign raw_cc = '{cc1: cc1_term_i, cc2: cc2_term_i};

    tcdfp_deglitch #(
        .CYCLES(DEGLITCH_CYCLES)
    ) u_deglitch (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .run_i(state_ff.monitor),
        .raw_i(raw_cc),
        .stable_o(stable_cc),
        .settled_o(settled)
    );

    // Exactly one line showing Rd is a UFP; Rd on both is a debug accessory
    assign ufp_cc1 = (stable_cc.cc1 == TERM_RD) && (stable_cc.cc2 != TERM_RD);
    assign ufp_cc2 = (stable_cc.cc2 == TERM_RD) && (stable_cc.cc1 != TERM_RD);
    assign attach_seen = raw_cc.cc1 != TERM_OPEN || raw_cc.cc2 != TERM_OPEN;

    ////////////////////////////////////////////////////////////////////////////
    // Advertisement level from select pins

    function automatic tcdfp_adv_t adv_from_sel(input logic charge_select, input logic hi);
        tcdfp_adv_t lvl;
        lvl = ADV_STD;
        if (charge_select) begin
            lvl = hi ? ADV_3A0 : ADV_1A5;
        end
        return lvl;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_state = state_ff;
        // Selects may move at any time; level follows next cycle
        nxt_state.adv = adv_from_sel(charge_select_i, high_current_select_i);
        case (state_ff.st)
            ST_IDLE: begin
                nxt_state.outs = OUT_RST;
                nxt_state.monitor = 1'b0;
                if (aux_uvlo_ok_i) begin
                    nxt_state.st = ST_WAIT_EN;
                end
            end
            ST_WAIT_EN: begin
                if (enable_i) begin
                    nxt_state.st = ST_UNATTACHED;
                    nxt_state.monitor = 1'b1;
                end
            end
            ST_UNATTACHED: begin
                nxt_state.monitor = 1'b1;
                nxt_state.outs = OUT_RST;
                if (attach_seen) begin
                    nxt_state.st = ST_DEGLITCH;
                end
            end
            ST_DEGLITCH: begin
                if (settled) begin
                    if (stable_cc.cc1 == TERM_RA && stable_cc.cc2 == TERM_RA) begin
                        nxt_state.st = ST_AUDIO;
                        nxt_state.outs.audio_oe = 1'b1;
                    end else if (stable_cc.cc1 == TERM_RD && stable_cc.cc2 == TERM_RD) begin
                        nxt_state.st = ST_DEBUG;
                        nxt_state.outs.debug_oe = 1'b1;
                    end else if ((ufp_cc1 || ufp_cc2) && !vbus_fault_i) begin
                        nxt_state.st = ST_ATTACHED;
                        nxt_state.on_cc2 = ufp_cc2;
                        nxt_state.outs.vbus_on = 1'b1;
                        nxt_state.outs.orient_oe = ufp_cc2;
                        // VCONN only onto the Ra line opposite the UFP
                        nxt_state.outs.vconn_cc2 = ufp_cc1 && stable_cc.cc2 == TERM_RA;
                        nxt_state.outs.vconn_cc1 = ufp_cc2 && stable_cc.cc1 == TERM_RA;
                    end else if (stable_cc.cc1 == TERM_OPEN && stable_cc.cc2 == TERM_OPEN) begin
                        nxt_state.st = ST_UNATTACHED;
                    end
                end
            end
            ST_ATTACHED: begin
                if (settled && (state_ff.on_cc2 ? stable_cc.cc2 : stable_cc.cc1) != TERM_RD) begin
                    // Detach drops VBUS and VCONN together
                    nxt_state.st = ST_UNATTACHED;
                    nxt_state.outs = OUT_RST;
                end else begin
                    // Fault on VBUS rail opens the switch
                    if (vbus_fault_i) begin
                        nxt_state.outs.vbus_on = 1'b0;
                    end
                    // VCONN path opens on over-current
                    if (vconn_ilim_i) begin
                        nxt_state.outs.vconn_cc1 = 1'b0;
                        nxt_state.outs.vconn_cc2 = 1'b0;
                    end
                end
            end
            ST_AUDIO: begin
                if (settled && stable_cc.cc2 != TERM_RA) begin
                    nxt_state.st = ST_UNATTACHED;
                    nxt_state.outs = OUT_RST;
                end
            end
            ST_DEBUG: begin
                if (settled && stable_cc.cc1 != TERM_RD) begin
                    nxt_state.st = ST_UNATTACHED;
                    nxt_state.outs = OUT_RST;
                end
            end
            default: begin
                nxt_state.st = ST_IDLE;
                nxt_state.outs = OUT_RST;
            end
        endcase
        // Supply loss returns to idle; enable low shuts everything but the advertised level
        if (!aux_uvlo_ok_i) begin
            nxt_state.st = ST_IDLE;
            nxt_state.outs = OUT_RST;
            nxt_state.monitor = 1'b0;
        end else if (!enable_i && state_ff.st != ST_IDLE) begin
            nxt_state.st = ST_WAIT_EN;
            nxt_state.outs = OUT_RST;
            nxt_state.monitor = 1'b0;
        end
        // Advertisement shown on the line that carries the UFP
        nxt_state.adv_cc1 = nxt_state.outs.vbus_on && !nxt_state.on_cc2;
        nxt_state.adv_cc2 = nxt_state.outs.vbus_on && nxt_state.on_cc2;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_ff <= '{st: ST_IDLE, outs: OUT_RST, adv: ADV_STD, on_cc2: 1'b0, monitor: 1'b0,
                adv_cc1: 1'b0, adv_cc2: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs from the state register; flag levels tied low

    assign bus_power_input_sw_o = state_ff.outs.vbus_on;
    assign cable_power_input_cc1_o = state_ff.outs.vconn_cc1;
    assign cable_power_input_cc2_o = state_ff.outs.vconn_cc2;
    assign adv_level_o = state_ff.adv;
    assign adv_cc1_o = state_ff.adv_cc1;
    assign adv_cc2_o = state_ff.adv_cc2;
    assign monitor_on_o = state_ff.monitor;
    assign orientation_flag_o = 1'b0;
    assign orientation_flag_oe_o = state_ff.outs.orient_oe;
    assign audio_flag_o = 1'b0;
    assign audio_flag_oe_o = state_ff.outs.audio_oe;
    assign debug_flag_o = 1'b0;
    assign debug_flag_oe_o = state_ff.outs.debug_oe;

endmodule

`default_nettype wire

// ### tb/tcdfp_ctrl_monitor.sv
// Checker for the Type-C DFP attach and power control block
`timescale 1ns/1ps
`default_nettype none

module tcdfp_ctrl_monitor
    import tcdfp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Inputs
    input wire logic aux_uvlo_ok_i,
    input wire logic enable_i,
    input wire logic charge_select_i,
    input wire logic high_current_select_i,
    input var tcdfp_term_t cc1_term_i,
    input var tcdfp_term_t cc2_term_i,
    input wire logic vbus_fault_i,
    input wire logic vconn_ilim_i,
    // Outputs
    input wire logic bus_power_input_sw_o,
    input wire logic cable_power_input_cc1_o,
    input wire logic cable_power_input_cc2_o,
    input var tcdfp_adv_t adv_level_o,
    input wire logic monitor_on_o,
    input wire logic orientation_flag_oe_o,
    input wire logic audio_flag_oe_o,
    input wire logic debug_flag_oe_o
);
    logic [5:0] open_ff;
    tcdfp_adv_t exp_adv;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Cycles with both lines open, saturating
    always_ff @(posedge clk_i) begin
        if (srst_i || cc1_term_i != TERM_OPEN || cc2_term_i != TERM_OPEN) begin
            open_ff <= 6'h00;
        end else if (open_ff != 6'h3F) begin
            open_ff <= open_ff + 6'h01;
        end
    end
    assign exp_adv = !charge_select_i ? ADV_STD : (high_current_select_i ? ADV_3A0 : ADV_1A5);
    uvlo_idle_a: assert property (!aux_uvlo_ok_i |=> !monitor_on_o)
        else $error("monitor on without standby supply");
    disable_all_a: assert property (!enable_i |=> !(bus_power_input_sw_o || cable_power_input_cc1_o
        || cable_power_input_cc2_o || orientation_flag_oe_o || audio_flag_oe_o || debug_flag_oe_o || monitor_on_o))
        else $error("output active while disabled");
    vbus_stable_a: assert property ($rose(bus_power_input_sw_o) |-> $past(cc1_term_i) == $past(cc1_term_i, 9)
        && $past(cc2_term_i) == $past(cc2_term_i, 9) && (($past(cc1_term_i) == TERM_RD) != ($past(cc2_term_i) == TERM_RD)))
        else $error("bus power on without settled single sink");
    detach_off_a: assert property (open_ff > 6'h20 |-> !(bus_power_input_sw_o || cable_power_input_cc1_o
        || cable_power_input_cc2_o)) else $error("power kept after detach");
    vconn_side_a: assert property ($rose(cable_power_input_cc2_o) |-> $past(cc2_term_i) == TERM_RA)
        else $error("cable power on wrong line");
    orient_cc2_a: assert property ($rose(orientation_flag_oe_o) |-> $past(cc2_term_i) == TERM_RD)
        else $error("orientation flag without sink on second line");
    audio_det_a: assert property ($rose(audio_flag_oe_o) |-> $past(cc1_term_i) == TERM_RA && $past(cc2_term_i) == TERM_RA)
        else $error("audio flag without two cable marks");
    debug_det_a: assert property ($rose(debug_flag_oe_o) |-> $past(cc1_term_i) == TERM_RD && $past(cc2_term_i) == TERM_RD)
        else $error("debug flag without two sinks");
    adv_follow_a: assert property (!$past(srst_i) |-> adv_level_o == $past(exp_adv))
        else $error("advertised level does not follow selects");
    vbus_fault_a: assert property (vbus_fault_i |=> !bus_power_input_sw_o)
        else $error("bus power kept during fault");
    vconn_limit_a: assert property (vconn_ilim_i |=> !cable_power_input_cc1_o && !cable_power_input_cc2_o)
        else $error("cable power kept at current limit");
    cover property ($rose(bus_power_input_sw_o));
    cover property ($rose(audio_flag_oe_o));
    cover property ($rose(debug_flag_oe_o));
endmodule

bind tcdfp_ctrl tcdfp_ctrl_monitor u_tcdfp_ctrl_monitor (.clk_i, .srst_i, .aux_uvlo_ok_i, .enable_i, .charge_select_i,
    .high_current_select_i, .cc1_term_i, .cc2_term_i, .vbus_fault_i, .vconn_ilim_i, .bus_power_input_sw_o,
    .cable_power_input_cc1_o, .cable_power_input_cc2_o, .adv_level_o, .monitor_on_o, .orientation_flag_oe_o,
    .audio_flag_oe_o, .debug_flag_oe_o);

`default_nettype wire

// ### tb/tcdfp_ufp_model.sv
// Terminations that a sink, cable or accessory puts on the CC lines
`timescale 1ns/1ps
`default_nettype none

module tcdfp_ufp_model
    import tcdfp_pkg::*;
(
    // Attachment chosen by the bench
    input wire logic [2:0] mode_i,
    // Terminations on both lines
    output var tcdfp_cc_t cc_o
);
    always_comb begin
        case (mode_i)
            3'h1: cc_o = '{TERM_RD, TERM_RA};
            3'h2: cc_o = '{TERM_RA, TERM_RD};
            3'h3: cc_o = '{TERM_RA, TERM_RA};
            3'h4: cc_o = '{TERM_RD, TERM_RD};
            3'h5: cc_o = '{TERM_RA, TERM_OPEN};
            3'h6: cc_o = '{TERM_OPEN, TERM_RD};
            default: cc_o = '{TERM_OPEN, TERM_OPEN};
        endcase
    end
endmodule

`default_nettype wire

// ### tb/test_tcdfp_ctrl.sv
// Testbench for the Type-C DFP attach and power control block
`timescale 1ns/1ps
`default_nettype none

module test_tcdfp_ctrl
    import tcdfp_pkg::*;
;
    logic clk_i, srst_i, aux, en, charge_select, hi, flt, ilim, vbus, v1, v2, a1, a2, mon, of, oo, af, ao, df, dbo;
    logic [2:0] mode;
    tcdfp_cc_t cc;
    tcdfp_adv_t advl;
    int err_count = 0;
    int n_checks = 0;

    tcdfp_ufp_model u_tcdfp_ufp_model (.mode_i(mode), .cc_o(cc));
    tcdfp_ctrl u_tcdfp_ctrl (.clk_i(clk_i), .srst_i(srst_i), .aux_uvlo_ok_i(aux), .enable_i(en),
        .charge_select_i(charge_select), .high_current_select_i(hi), .cc1_term_i(cc.cc1), .cc2_term_i(cc.cc2),
        .vbus_fault_i(flt), .vconn_ilim_i(ilim), .bus_power_input_sw_o(vbus), .cable_power_input_cc1_o(v1),
        .cable_power_input_cc2_o(v2), .adv_level_o(advl), .adv_cc1_o(a1), .adv_cc2_o(a2), .monitor_on_o(mon),
        .orientation_flag_o(of), .orientation_flag_oe_o(oo), .audio_flag_o(af), .audio_flag_oe_o(ao),
        .debug_flag_o(df), .debug_flag_oe_o(dbo));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic drive(input logic [2:0] m);
        @(posedge clk_i);
        mode <= m;
    endtask
    task automatic wait_vbus(input logic v, output int n);
        n = 0;
        while (vbus !== v && n < 60) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_startup;
        drive(3'h1);
        cyc(40);
        check({mon, vbus}, 2'h0);
        @(posedge clk_i);
        aux <= 1'b1;
        cyc(40);
        check({mon, vbus}, 2'h0);
        drive(3'h0);
        en <= 1'b1;
        cyc(3);
        check(mon, 1'b1);
        $display("startup test done");
    endtask
    // Sink attach after a glitch, select sweep, then detach
    task automatic t_attach(input logic [2:0] m, input logic [2:0] exp);
        int n;
        drive(m);
        cyc(10);
        drive(3'h0);
        drive(m);
        wait_vbus(1'b1, n);
        check(n >= 16 && n < 60, 1'b1);
        check({v1, v2, oo}, exp);
        check({a1, a2}, {~exp[0], exp[0]});
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            charge_select <= i[1];
            hi <= i[0];
            cyc(2);
            check(advl, i[1] ? (i[0] ? ADV_3A0 : ADV_1A5) : ADV_STD);
        end
        drive(3'h0);
        wait_vbus(1'b0, n);
        check({n < 60, v1, v2}, 3'h4);
        $display("attach test done");
    endtask
    task automatic t_access;
        drive(3'h3);
        cyc(40);
        check({ao, vbus}, 2'h2);
        drive(3'h5);
        cyc(40);
        check(ao, 1'b0);
        drive(3'h4);
        cyc(40);
        check({dbo, vbus}, 2'h2);
        drive(3'h6);
        cyc(40);
        check(dbo, 1'b0);
        check({of, af, df}, 3'h0);
        drive(3'h0);
        cyc(40);
        $display("accessory test done");
    endtask
    task automatic t_fault;
        int n;
        drive(3'h2);
        wait_vbus(1'b1, n);
        @(posedge clk_i);
        flt <= 1'b1;
        cyc(2);
        check({vbus, v1}, 2'h1);
        @(posedge clk_i);
        ilim <= 1'b1;
        cyc(2);
        check(v1, 1'b0);
        @(posedge clk_i);
        {en, flt, ilim} <= 3'h0;
        cyc(2);
        check({mon, oo, vbus}, 3'h0);
        drive(3'h0);
        en <= 1'b1;
        cyc(40);
        $display("fault test done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        {srst_i, aux, en, charge_select, hi, flt, ilim} = 7'h40;
        mode = 3'h0;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        t_startup;
        t_attach(3'h1, 3'h2);
        t_attach(3'h2, 3'h5);
        t_attach(3'h6, 3'h1);
        t_access;
        t_fault;
        end_of_test;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        end_of_test;
    end
endmodule

`default_nettype wire
